// ---- inc/vml_pkg.sv ----
/*
  Shared constants, types and helpers of the vector memory loader.
  Assumes one tester clock domain and one pin per loader instance.
*/
`default_nettype none

package vml_pkg;
    // Vector address and byte-row geometry
    localparam int VEC_AW = 12;
    localparam int ROW_AW = VEC_AW - 2;
    localparam int BANK_AW = 2;
    localparam int RAM_AW = BANK_AW + ROW_AW;
    localparam int LEN_W = 20;
    localparam int VEC_PER_BYTE_LOG2 = 2;
    localparam logic [LEN_W-1:0] VMEM_VECTORS = 20'h01000;
    localparam logic [LEN_W-1:0] ADDR_RESET = 20'h00000;
    localparam logic [LEN_W-1:0] LOW_VEC_MASK = 20'h00003;
    // Power-on fill: drive low with tristate off, compare don't care
    localparam logic [7:0] FILL_DRIVE = 8'h00;
    localparam logic [7:0] FILL_RECV = 8'hFF;
    // Keeps the upper bit of every vector pair
    localparam logic [7:0] UPPER_BITS = 8'hAA;

    typedef enum logic [2:0] {
        single_rate_mode, double_rate_mode, pin_pair_interleave_mode,
        quad_pair_interleave_mode, quad_rate_mode, quad_compare_mode
    } pin_mode_t;

    typedef enum logic [2:0] {
        load_drive_vectors, read_drive_vectors, load_expect_vectors,
        read_expect_vectors, set_vector_base, set_first_free_vector
    } cmd_t;

    typedef enum logic [3:0] {
        err_none, err_addr_limit, err_len_block, err_len_invalid, err_start_limit,
        err_multi_pin, err_not_realtime, err_config, err_transfer
    } err_t;

    // Number of data sections in a block, as a power of two
    function automatic logic [1:0] section_shift(input pin_mode_t mode);
        case (mode)
            pin_pair_interleave_mode, quad_pair_interleave_mode, quad_rate_mode: section_shift = 2'h1;
            quad_compare_mode: section_shift = 2'h2;
            default: section_shift = 2'h0;
        endcase
    endfunction : section_shift
endpackage : vml_pkg

`default_nettype wire

// ---- inc/vram_if.sv ----
/*
  Port bundle between the loader controller and its vector RAM.
  Assumes read data appear one clock after the address.
*/
`default_nettype none

interface vram_if #(parameter int AW = 12, parameter int DW = 8);
    logic we;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    modport ctrl (output we, output addr, output wdata, input rdata);
    modport mem (input we, input addr, input wdata, output rdata);
endinterface : vram_if

`default_nettype wire

// ---- src/vector_ram.sv ----
/*
  Byte-wide vector RAM, four vectors per byte, registered read.
  Assumes the controller fills it after power-up.
*/
`default_nettype none

module vector_ram #(
    parameter int AW = 12,
    parameter int DW = 8
) (
    // Clock
    input wire logic i_core_clk,
    // Controller side
    vram_if.mem ram
);
    logic [DW-1:0] mem_r [2**AW];
    logic [DW-1:0] rdata_r;

    always_ff @(posedge i_core_clk) begin
        if (ram.we) begin
            mem_r[ram.addr] <= ram.wdata;
        end
        rdata_r <= mem_r[ram.addr];
    end

    assign ram.rdata = rdata_r;
endmodule : vector_ram

`default_nettype wire

// ---- src/load_checker.sv ----
/*
  Combinational validation and geometry of one transfer request.
  Assumes the base address is the loader's current register value.
*/
`default_nettype none

module load_checker
    import vml_pkg::*;
#(
    parameter logic [LEN_W-1:0] VMEM = VMEM_VECTORS
) (
    // Request
    input wire cmd_t i_cmd,
    input wire pin_mode_t i_mode,
    input wire logic [LEN_W-1:0] i_base,
    input wire logic [LEN_W-1:0] i_value,
    input wire logic [LEN_W-1:0] i_count,
    input wire logic [LEN_W-1:0] i_block_len,
    input wire logic [7:0] i_pin_count,
    // Pin and tester state
    input wire logic i_pin_is_receiver,
    input wire logic i_word_mask_pin,
    input wire logic i_realtime_compare,
    input wire logic i_cfg_conflict,
    // Results
    output err_t o_err,
    output logic [LEN_W-1:0] o_valid_bytes,
    output logic [LEN_W-1:0] o_start_row,
    output logic o_trunc,
    output logic [LEN_W-1:0] o_first_free
);
    wire [LEN_W-1:0] vstart = i_base + i_value;
    wire [1:0] shift = section_shift(i_mode);
    wire is_load = (i_cmd == load_drive_vectors) || (i_cmd == load_expect_vectors);
    wire is_read = (i_cmd == read_drive_vectors) || (i_cmd == read_expect_vectors);
    wire is_drive = (i_cmd == load_drive_vectors) || (i_cmd == read_drive_vectors);
    wire is_expect = (i_cmd == load_expect_vectors) || (i_cmd == read_expect_vectors);
    // Minimum bytes per section the host must supply
    wire [LEN_W-1:0] valid = (((vstart & LOW_VEC_MASK) + i_count - 20'h00001) >> VEC_PER_BYTE_LOG2) + 20'h00001;
    wire [LEN_W-1:0] need = valid << shift;
    wire [LEN_W-1:0] rows = VMEM >> VEC_PER_BYTE_LOG2;
    wire [LEN_W-1:0] vend = vstart + i_count;
    // No drive data in quad compare mode, drive on driver pins only
    wire conflict = i_cfg_conflict || (is_drive && (i_mode == quad_compare_mode))
        || (is_drive && (i_pin_is_receiver || i_word_mask_pin)) || (is_expect && !i_pin_is_receiver);
    wire bad_count = (i_count == 20'h00000) || (i_count > VMEM);

    always_comb begin
        o_err = err_none;
        if (i_cmd == set_vector_base) begin
            if (i_value >= VMEM) o_err = err_addr_limit;
        end else if (i_cmd == set_first_free_vector) begin
            if (i_value > VMEM) o_err = err_addr_limit;
        end else if (is_load && i_pin_count != 8'h01) begin
            o_err = err_multi_pin;
        end else if (is_expect && !i_realtime_compare) begin
            o_err = err_not_realtime;
        end else if (conflict) begin
            o_err = err_config;
        end else if (is_read && bad_count) begin
            o_err = err_len_invalid;
        end else if (vstart >= VMEM) begin
            o_err = err_start_limit;
        end else if (is_load && (i_count == 20'h00000 || need > i_block_len)) begin
            o_err = err_len_block;
        end
    end

    assign o_valid_bytes = valid;
    assign o_start_row = vstart >> VEC_PER_BYTE_LOG2;
    assign o_trunc = (o_start_row + valid) > rows;
    assign o_first_free = (vend > VMEM) ? VMEM : vend;
endmodule : load_checker

`default_nettype wire

// ---- src/vector_memory_loader.sv ----
/*
  Vector memory loader for one tester pin: unpacks packed byte blocks
  into the pin's vector RAM, reads them back, keeps base and first-free.
  Assumes the host command processor holds each command until taken and
  streams the block bytes after a load command.
*/
`default_nettype none

module vector_memory_loader
    import vml_pkg::*;
#(
    parameter logic [LEN_W-1:0] VMEM = VMEM_VECTORS
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Pin configuration and tester state
    input wire pin_mode_t i_mode,
    input wire logic i_pin_is_receiver,
    input wire logic i_word_mask_pin,
    input wire logic i_realtime_compare,
    input wire logic i_cfg_conflict,
    // Command
    input wire logic i_cmd_valid,
    input wire cmd_t i_cmd,
    input wire logic [LEN_W-1:0] i_cmd_value,
    input wire logic [LEN_W-1:0] i_cmd_count,
    input wire logic [LEN_W-1:0] i_block_len,
    input wire logic [7:0] i_pin_count,
    input wire logic i_abort,
    output logic o_cmd_ready,
    // Load byte stream
    input wire logic i_byte_valid,
    input wire logic [7:0] i_byte,
    output logic o_byte_ready,
    // Readback byte stream
    output logic o_rd_valid,
    output logic [7:0] o_rd_byte,
    input wire logic i_rd_ready,
    // Status
    output logic o_busy,
    output logic o_done,
    output logic o_error,
    output err_t o_err_code,
    output logic o_trunc_warn,
    output logic [LEN_W-1:0] o_base_addr,
    output logic [LEN_W-1:0] o_first_free
);
    typedef enum logic [2:0] {st_fill, st_idle, st_load, st_drain, st_rd_addr, st_rd_out} state_t;

    state_t state_r;
    cmd_t cmd_r;
    pin_mode_t mode_r;
    logic [RAM_AW-1:0] fill_r;
    logic [LEN_W-1:0] j_r;
    logic [LEN_W-1:0] cnt_r;
    logic [LEN_W-1:0] len_r;
    logic [LEN_W-1:0] valid_r;
    logic [LEN_W-1:0] row0_r;
    logic [LEN_W-1:0] ff_new_r;
    logic [LEN_W-1:0] base_r;
    logic [LEN_W-1:0] ff_r;

    logic [1:0] k_r;
    logic [1:0] shift_r;

    logic trunc_r;
    logic oob_r;
    logic done_r;
    logic error_r;
    logic warn_r;
    err_t err_code_r;

    err_t chk_err;
    logic [LEN_W-1:0] chk_valid, chk_row, chk_ff;
    logic chk_trunc;

    vram_if #(.AW(RAM_AW), .DW(8)) ram_bus ();

    vector_ram #(.AW(RAM_AW), .DW(8)) u_ram (
        .i_core_clk(i_core_clk),
        .ram(ram_bus.mem)
    );

    load_checker #(.VMEM(VMEM)) u_check (
        .i_cmd(i_cmd),
        .i_mode(i_mode),
        .i_base(base_r),
        .i_value(i_cmd_value),
        .i_count(i_cmd_count),
        .i_block_len(i_block_len),
        .i_pin_count(i_pin_count),
        .i_pin_is_receiver(i_pin_is_receiver),
        .i_word_mask_pin(i_word_mask_pin),
        .i_realtime_compare(i_realtime_compare),
        .i_cfg_conflict(i_cfg_conflict),
        .o_err(chk_err),
        .o_valid_bytes(chk_valid),
        .o_start_row(chk_row),
        .o_trunc(chk_trunc),
        .o_first_free(chk_ff)
    );

    // Section walk; stride is the block split evenly, odd leftovers trail the last section
    wire [LEN_W-1:0] stride = len_r >> shift_r;
    wire [1:0] last_k = 2'((3'h1 << shift_r) - 3'h1);
    wire [LEN_W-1:0] rows = VMEM >> VEC_PER_BYTE_LOG2;
    wire [LEN_W-1:0] row = row0_r + j_r;
    wire row_in_mem = row < rows;

    wire cmd_take = i_cmd_valid && (state_r == st_idle);
    wire byte_take = i_byte_valid && ((state_r == st_load) || (state_r == st_drain));
    wire block_last = cnt_r == (len_r - 20'h00001);

    wire load_write = byte_take && (state_r == st_load) && (j_r < valid_r) && row_in_mem;
    wire sec_end_load = (j_r == stride - 20'h00001) && (k_r != last_k);

    wire rd_step = (state_r == st_rd_out) && i_rd_ready;
    wire sec_end_rd = j_r == (valid_r - 20'h00001);
    wire rd_last = sec_end_rd && (k_r == last_k);

    wire is_load_cmd = (i_cmd == load_drive_vectors) || (i_cmd == load_expect_vectors);
    wire is_read_cmd = (i_cmd == read_drive_vectors) || (i_cmd == read_expect_vectors);

    wire busy_xfer = (state_r == st_load) || (state_r == st_rd_addr) || (state_r == st_rd_out);
    wire aborted = busy_xfer && i_abort;
    // Pin-pair and quad-pair drive write zero lower bits; word-mask lower bits are ignored
    wire mask_low = ((cmd_r == load_drive_vectors) && ((mode_r == pin_pair_interleave_mode)
        || (mode_r == quad_pair_interleave_mode))) || ((cmd_r == load_expect_vectors) && i_word_mask_pin);
    // Other modes store the byte as packed: vector 0 in the top pair
    wire [7:0] load_byte = mask_low ? (i_byte & UPPER_BITS) : i_byte;
    wire [7:0] fill_byte = i_pin_is_receiver ? FILL_RECV : FILL_DRIVE;

    // Whole bytes are written, so neighbouring vectors in a byte are overwritten
    assign ram_bus.we = (state_r == st_fill) || load_write;
    assign ram_bus.addr = (state_r == st_fill) ? fill_r : {k_r, row[ROW_AW-1:0]};
    assign ram_bus.wdata = (state_r == st_fill) ? fill_byte : load_byte;

    assign o_cmd_ready = state_r == st_idle;
    assign o_byte_ready = (state_r == st_load) || (state_r == st_drain);
    assign o_rd_valid = state_r == st_rd_out;
    assign o_rd_byte = oob_r ? FILL_DRIVE : ram_bus.rdata;
    assign o_busy = state_r != st_idle;
    assign o_done = done_r;
    assign o_error = error_r;
    assign o_err_code = err_code_r;
    assign o_trunc_warn = warn_r;
    assign o_base_addr = base_r;
    assign o_first_free = ff_r;

    always_ff @(posedge i_core_clk) begin
        if (!i_reset_n) begin
            state_r <= st_fill;
            fill_r <= '0;
            base_r <= ADDR_RESET;
            ff_r <= ADDR_RESET;
            cmd_r <= load_drive_vectors;
            mode_r <= single_rate_mode;
            j_r <= '0;
            cnt_r <= '0;
            len_r <= '0;
            valid_r <= '0;
            row0_r <= '0;
            ff_new_r <= '0;
            k_r <= '0;
            shift_r <= '0;
            trunc_r <= 1'b0;
            oob_r <= 1'b0;
            done_r <= 1'b0;
            error_r <= 1'b0;
            warn_r <= 1'b0;
            err_code_r <= err_none;
        end else begin
            done_r <= 1'b0;
            error_r <= 1'b0;
            warn_r <= 1'b0;

            case (state_r)
                st_fill: begin
                    fill_r <= fill_r + 1'b1;
                    if (&fill_r) state_r <= st_idle;
                end

                st_idle: begin
                    if (cmd_take) begin
                        cmd_r <= i_cmd;
                        mode_r <= i_mode;
                        shift_r <= section_shift(i_mode);
                        valid_r <= chk_valid;
                        row0_r <= chk_row;
                        trunc_r <= chk_trunc;
                        ff_new_r <= chk_ff;
                        len_r <= i_block_len;
                        j_r <= '0;
                        cnt_r <= '0;
                        k_r <= '0;
                        err_code_r <= chk_err;
                        if (chk_err != err_none) begin
                            error_r <= 1'b1;
                            if (is_load_cmd && i_block_len != 20'h00000) state_r <= st_drain;
                        end else if (i_cmd == set_vector_base) begin
                            base_r <= i_cmd_value;
                            done_r <= 1'b1;
                        end else if (i_cmd == set_first_free_vector) begin
                            ff_r <= i_cmd_value;
                            done_r <= 1'b1;
                        end else if (is_read_cmd) begin
                            state_r <= st_rd_addr;
                        end else begin
                            state_r <= st_load;
                        end
                    end
                end

                st_load, st_drain: begin
                    if (aborted) begin
                        error_r <= 1'b1;
                        err_code_r <= err_transfer;
                        state_r <= st_idle;
                    end else if (byte_take) begin
                        cnt_r <= cnt_r + 20'h00001;
                        j_r <= sec_end_load ? 20'h00000 : j_r + 20'h00001;
                        k_r <= sec_end_load ? k_r + 2'h1 : k_r;
                        if (block_last) begin
                            state_r <= st_idle;
                            if (state_r == st_load) begin
                                done_r <= 1'b1;
                                ff_r <= ff_new_r;
                                warn_r <= trunc_r;
                            end
                        end
                    end
                end

                st_rd_addr: begin
                    oob_r <= !row_in_mem;
                    state_r <= aborted ? st_idle : st_rd_out;
                    if (aborted) begin
                        error_r <= 1'b1;
                        err_code_r <= err_transfer;
                    end
                end

                st_rd_out: begin
                    if (aborted) begin
                        error_r <= 1'b1;
                        err_code_r <= err_transfer;
                        state_r <= st_idle;
                    end else if (rd_step) begin
                        j_r <= sec_end_rd ? 20'h00000 : j_r + 20'h00001;
                        k_r <= sec_end_rd ? k_r + 2'h1 : k_r;
                        state_r <= rd_last ? st_idle : st_rd_addr;
                        done_r <= rd_last;
                    end
                end

                default: state_r <= st_idle;
            endcase
        end
    end

    chk_power_on_ptrs: assert property (@(posedge i_core_clk)
        $rose(i_reset_n) |-> (o_base_addr == ADDR_RESET) && (o_first_free == ADDR_RESET))
        else $error("Pointers not cleared after reset");

    chk_fill_pattern: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (state_r == st_fill) |-> ram_bus.we && (ram_bus.wdata == (i_pin_is_receiver ? FILL_RECV : FILL_DRIVE)))
        else $error("Power-up fill writes wrong pattern");

    chk_first_free_update: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (state_r == st_load) && byte_take && block_last && !i_abort |=> o_done && (o_first_free == $past(ff_new_r)))
        else $error("First-free not updated after load");

    chk_base_limit: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        cmd_take && (i_cmd == set_vector_base) && (i_cmd_value >= VMEM)
        |=> o_error && (o_err_code == err_addr_limit) && $stable(o_base_addr))
        else $error("Out-of-range base accepted");

    chk_single_pin: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        cmd_take && is_load_cmd && (i_pin_count != 8'h01) |=> o_error ##1 !o_done [*2])
        else $error("Multi-pin load not refused");

    chk_realtime_only: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        cmd_take && (i_cmd == read_expect_vectors) && !i_realtime_compare |=> o_error && !o_rd_valid)
        else $error("Expect readback outside real-time compare");

    chk_pair_low_zero: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        load_write && (cmd_r == load_drive_vectors) && (mode_r == pin_pair_interleave_mode)
        |-> ((ram_bus.wdata & ~UPPER_BITS) == 8'h00))
        else $error("Pin-pair drive lower bits not zero");

    chk_trunc_warning: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (state_r == st_load) && byte_take && block_last && trunc_r && !i_abort |=> o_trunc_warn && !o_error)
        else $error("Truncation not reported as warning");

    chk_abort_error: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        aborted |=> o_error && (o_err_code == err_transfer) && o_cmd_ready)
        else $error("Abort did not report transfer error");

    chk_quad_no_drive: assert property (@(posedge i_core_clk) disable iff (!i_reset_n)
        cmd_take && (i_cmd == load_drive_vectors) && (i_mode == quad_compare_mode) && (i_pin_count == 8'h01)
        |=> o_error && (o_err_code == err_config))
        else $error("Drive load accepted in quad compare mode");

    cov_load_done: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (state_r == st_load) ##[1:1000] o_done);
    cov_readback: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (state_r == st_rd_out) && i_rd_ready && rd_last);
    cov_quad_sections: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
        load_write && (k_r == 2'h3));
    cov_abort: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
        aborted);
    cov_refused_drain: cover property (@(posedge i_core_clk) disable iff (!i_reset_n)
        (state_r == st_drain) && byte_take && block_last);
endmodule : vector_memory_loader

`default_nettype wire

// ---- verif/host_model.sv ----
/*
  Host command processor stand-in: streams queued block bytes in order.
  Assumes the loader takes a byte on a rising edge with valid and ready.
*/
`default_nettype none
module host_model (
    // Clock and handshake
    input wire logic i_core_clk,
    input wire logic i_byte_ready,
    // Byte stream
    output logic o_byte_valid,
    output logic [7:0] o_byte
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] blk[$];
    initial begin
        o_byte_valid = 1'b0;
        o_byte = 8'h00;
    end
    // Whole block offered byte by byte, as queued
    always @(posedge i_core_clk) begin
        if (o_byte_valid && i_byte_ready) begin
            void'(blk.pop_front());
        end
        #1;
        o_byte_valid = (blk.size() > 0);
        // Idle line toggles so a stale byte never looks fresh
        o_byte = o_byte_valid ? blk[0] : ~o_byte;
    end
endmodule : host_model
`default_nettype wire

// ---- verif/tb.sv ----
/*
  Self-checking bench of the vector memory loader.
  Assumes the default memory size and a driver pin unless stated.
*/
`default_nettype none
module tb import vml_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic i_core_clk, i_reset_n, i_pin_is_receiver, i_word_mask_pin, i_realtime_compare, i_cfg_conflict;
    pin_mode_t i_mode;
    cmd_t i_cmd;
    err_t o_err_code, e;
    logic i_cmd_valid, i_abort, o_cmd_ready, i_byte_valid, o_byte_ready, o_rd_valid, i_rd_ready;
    logic o_busy, o_done, o_error, o_trunc_warn, tr;
    logic [19:0] i_cmd_value, i_cmd_count, i_block_len, o_base_addr, o_first_free, b, o, c, vb;
    logic [7:0] i_pin_count, i_byte, o_rd_byte, q[$], rd[$];
    int bad_count, cmp_count, seed, n, j, k;
    vector_memory_loader dut (.i_core_clk, .i_reset_n, .i_mode, .i_pin_is_receiver, .i_word_mask_pin,
        .i_realtime_compare, .i_cfg_conflict, .i_cmd_valid, .i_cmd, .i_cmd_value, .i_cmd_count, .i_block_len,
        .i_pin_count, .i_abort, .o_cmd_ready, .i_byte_valid, .i_byte, .o_byte_ready, .o_rd_valid, .o_rd_byte,
        .i_rd_ready, .o_busy, .o_done, .o_error, .o_err_code, .o_trunc_warn, .o_base_addr, .o_first_free);
    host_model host (.i_core_clk, .i_byte_ready(o_byte_ready), .o_byte_valid(i_byte_valid), .o_byte(i_byte));
    task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    // Holds the command until taken, then collects readback until the end pulse
    task automatic run(input cmd_t cm, input logic [19:0] v = '0, input logic [19:0] cn = '0,
                       input logic [19:0] ln = '0, input logic [7:0] pc = 8'h01);
        @(posedge i_core_clk);
        #1;
        i_cmd = cm;
        i_cmd_value = v;
        i_cmd_count = cn;
        i_block_len = ln;
        i_pin_count = pc;
        i_cmd_valid = 1'b1;
        rd.delete();
        n = 0;
        while (o_cmd_ready !== 1'b1 && n < 9000) begin
            @(posedge i_core_clk);
            #1;
            n++;
        end
        @(posedge i_core_clk);
        #1;
        i_cmd_valid = 1'b0;
        while (o_done !== 1'b1 && o_error !== 1'b1 && n < 9000) begin
            if (o_rd_valid === 1'b1) rd.push_back(o_rd_byte);
            @(posedge i_core_clk);
            #1;
            n++;
        end
        if (n >= 9000) begin
            bad_count++;
            end_sim();
        end
        e = o_err_code;
        tr = o_trunc_warn;
    endtask : run
    initial begin
        i_core_clk = 1'b0;
        forever #2 i_core_clk = ~i_core_clk;
    end
    initial begin
        seed = 78045;
        {i_reset_n, i_pin_is_receiver, i_word_mask_pin, i_cfg_conflict, i_cmd_valid, i_abort} = '0;
        {i_realtime_compare, i_rd_ready} = 2'h3;
        i_mode = single_rate_mode;
        i_cmd = load_drive_vectors;
        {i_cmd_value, i_cmd_count, i_block_len, i_pin_count} = '0;
        repeat (6) @(posedge i_core_clk);
        #1;
        i_reset_n = 1'b1;
        check("base", o_base_addr, 0);
        check("first free", o_first_free, 0);
        check("busy", o_busy, 1);
        run(read_drive_vectors, '0, 20'h00004);
        check("fill", rd[0], FILL_DRIVE);
        $display("test power-on done");
        run(set_vector_base, VMEM_VECTORS);
        check("base limit", e, err_addr_limit);
        run(set_first_free_vector, VMEM_VECTORS + 20'h00001);
        check("free limit", e, err_addr_limit);
        run(read_drive_vectors);
        check("read count", e, err_len_invalid);
        run(load_drive_vectors, '0, 20'h00004, '0, 8'h02);
        check("pins", e, err_multi_pin);
        i_realtime_compare = 1'b0;
        run(load_expect_vectors, '0, 20'h00004);
        check("realtime", e, err_not_realtime);
        {i_realtime_compare, i_cfg_conflict} = 2'h3;
        run(load_drive_vectors, '0, 20'h00004);
        check("conflict", e, err_config);
        i_cfg_conflict = 1'b0;
        i_mode = quad_compare_mode;
        run(load_drive_vectors, '0, 20'h00004);
        check("quad compare drive", e, err_config);
        i_mode = single_rate_mode;
        host.blk.push_back(8'h5A);
        run(load_drive_vectors, '0, 20'h00008, 20'h00001);
        check("short block", e, err_len_block);
        i_abort = 1'b1;
        run(load_drive_vectors, '0, 20'h00004, 20'h00001);
        check("abort", e, err_transfer);
        i_abort = 1'b0;
        $display("test refusals done");
        run(set_vector_base, VMEM_VECTORS - 20'h00004);
        host.blk = '{8'hC3, 8'h3C};
        run(load_drive_vectors, '0, 20'h00008, 20'h00002);
        check("trunc", {tr, e}, {1'b1, err_none});
        check("trunc free", o_first_free, VMEM_VECTORS);
        run(load_drive_vectors, 20'h00004, 20'h00004);
        check("start", e, err_start_limit);
        $display("test limits done");
        run(set_vector_base);
        i_mode = pin_pair_interleave_mode;
        host.blk = '{8'hFF, 8'hFF};
        run(load_drive_vectors, '0, 20'h00004, 20'h00002);
        check("pair free", o_first_free, 20'h00004);
        run(read_drive_vectors, '0, 20'h00004);
        check("pair count", rd.size(), 2);
        check("pair", {rd[0], rd[1]}, 16'hAAAA);
        {i_realtime_compare, i_pin_is_receiver, i_word_mask_pin} = 3'h7;
        i_mode = quad_compare_mode;
        q = '{8'hC5, 8'h5C, 8'h96, 8'h69, 8'h3C};
        host.blk = q;
        run(load_expect_vectors, '0, 20'h00004, 20'h00005);
        run(read_expect_vectors, '0, 20'h00004);
        for (j = 0; j < 4; j++) check("quad", rd[j], q[j] & UPPER_BITS);
        {i_pin_is_receiver, i_word_mask_pin} = '0;
        $display("test pin-pair done");
        for (k = 0; k < 4; k++) begin
            i_mode = k[0] ? double_rate_mode : single_rate_mode;
            b = 20'($random(seed) & 1023);
            o = 20'($random(seed) & 7);
            c = 20'(($random(seed) & 15) + 1);
            vb = (((b + o) & LOW_VEC_MASK) + c - 20'h00001) / 4 + 20'h00001;
            q.delete();
            for (j = 0; j < vb; j++) q.push_back(8'($random(seed)));
            host.blk = q;
            run(set_vector_base, b);
            run(load_drive_vectors, o, c, vb);
            check("free", o_first_free, b + o + c);
            run(read_drive_vectors, o, c);
            for (j = 0; j < vb; j++) check("data", rd[j], q[j]);
        end
        $display("test random loads done");
        end_sim();
    end
endmodule : tb
`default_nettype wire
